/* File: inc/hcai_pkg.sv */
// package: constants and carrier types for the host command accept and interrupt block
package hcai_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IEN = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0C;
  // control register fields (write one to pulse, except busy, which takes the written value)
  localparam int CTRL_REPLY_BIT = 0;
  localparam int CTRL_REJECT_BIT = 1;
  localparam int CTRL_BUSY_BIT = 2;
  localparam int CTRL_SEEK_CLR_BIT = 3;
  // status register fields
  localparam int STAT_ACC_BIT = 0;
  localparam int STAT_REP_BIT = 1;
  localparam int STAT_REJ_BIT = 2;
  localparam int STAT_WRITE_BIT = 3;
  localparam int STAT_SEEK_BIT = 4;
  localparam int STAT_FC_LSB = 8;
  localparam int STAT_DATA_LSB = 16;
  // config register fields
  localparam int CFG_PROT_BIT = 4;
  localparam logic [3:0] DEV_ADDR_RST = 4'h0;
  // function code and director data fields
  localparam logic [3:0] FC_DIRECTOR = 4'h8;
  localparam int DIR_SEL_LSB = 2;
  localparam int DIR_SET_BIT = 5;
  localparam int DIR_CLR_IF_BIT = 6;
  localparam int DIR_CLR_INT_BIT = 7;
  localparam int SEEK_SRC = 0;
  localparam int STATUS_SEEK_BIT = 0;
  // backplane command carrier
  typedef struct packed {
    logic rd;          // read request
    logic wr;          // write request
    logic [3:0] adr_n; // equipment address, active low
    logic [3:0] fc_n;  // function code, active low
    logic prot_n;      // command protected, active low
    logic [15:0] data; // write data from processor
  } hcai_cmd_t;
  // answer flags carrier
  typedef struct packed {
    logic accepted;
    logic reply;
    logic reject;
  } hcai_flags_t;
endpackage

/* File: logic/hcai_ien.sv */
// eight-bit addressable interrupt enable latch with gating
`timescale 1ns/100ps
module hcai_ien #(
  parameter int N_EN = 8,
  parameter int N_SRC = 6
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset
  input wire logic clr, // synchronous clear of all enables
  input wire logic wr_en, // director write strobe
  input wire logic [2:0] sel, // addressed latch
  input wire logic set_val, // value written
  input wire logic [N_SRC-1:0] cond, // interrupt conditions
  output logic [N_EN-1:0] en_q, // enable latches
  output logic any_o // any enabled condition
);
  initial
  begin
    if (N_EN != 8 || N_SRC > N_EN)
      $error("hcai_ien: unsupported sizes");
  end

  // clear wins over a write in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      en_q <= '0;
    else if (clr)
      en_q <= '0;
    else if (wr_en)
      en_q[sel] <= set_val;
  end

  // each source gated by its own latch
  assign any_o = |(cond & en_q[N_SRC-1:0]);
endmodule

/* File: logic/hcai_top.sv */
// command acceptance, answer flags, interrupt enables and wishbone access
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module hcai_top #(
  parameter int N_SRC = 6
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic rst, // async reset, active high
  input wire hcai_pkg::hcai_cmd_t cmd_i, // backplane command
  input wire logic master_reset_in, // processor master reset
  input wire logic seek_alert_i, // seek complete pulse
  input wire logic [N_SRC-1:1] int_cond_i, // other interrupt conditions
  output logic [15:0] rd_data_o, // status data to processor
  output logic rd_data_oe, // read data drive enable
  output logic interrupt_request_n_o, // wired-or interrupt, low active
  output logic interrupt_request_n_oe, // high while pulling line low
  output hcai_pkg::hcai_flags_t flags_o, // accepted, reply, reject
  output logic clear_interface_o, // internal clear pulse
  input wire logic [7:0] wb_adr_i, // wishbone address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic wb_we_i, // write enable
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o // unmapped address
);
  initial
  begin
    if (N_SRC != 6)
      $error("hcai_top: six interrupt sources expected");
  end

  logic [3:0] fc;
  logic is_fc8;
  logic addr_match;
  logic qualified_select;
  logic protection_satisfied;
  logic busy_ok;
  logic prot_ok;
  logic accept_ok;
  logic director_function_decode;
  logic cmd_start;
  logic sel_d_q;
  logic accepted_q;
  logic reply_q;
  logic reject_q;
  logic busy_q;
  logic prot_cfg_q;
  logic [3:0] dev_addr_q;
  logic seek_done_latch_q;
  logic clear_interface;
  logic clear_interrupt_enables;
  logic [7:0] en_q;
  logic int_any;
  logic fw_reply_strobe;
  logic fw_reject_strobe;
  logic seek_clr_strobe;
  logic wb_req;
  logic wb_wr;
  logic wb_hit;
  logic [15:0] status_word;
  logic [3:0] fc_q;
  logic write_q;
  logic [15:0] data_q;

  // backplane address and function code lines are active low
  function automatic logic [3:0] inv4(input logic [3:0] v);
    inv4 = ~v;
  endfunction

  // command decode
  assign fc = inv4(cmd_i.fc_n);
  assign is_fc8 = (fc == hcai_pkg::FC_DIRECTOR);
  assign addr_match = (inv4(cmd_i.adr_n) == dev_addr_q);
  assign qualified_select = (cmd_i.rd | cmd_i.wr) & addr_match;
  assign protection_satisfied = ~prot_cfg_q | ~cmd_i.prot_n;
  assign busy_ok = ~busy_q | is_fc8;
  assign prot_ok = protection_satisfied | (is_fc8 & cmd_i.rd);
  assign accept_ok = busy_ok & prot_ok;
  // one decision per command, on the rising edge of the select
  assign cmd_start = qualified_select & ~sel_d_q;
  assign director_function_decode = is_fc8 & cmd_i.wr & cmd_start & accept_ok;

  // clears: interface clear and interrupt-enable clear
  assign clear_interface = master_reset_in
    | (director_function_decode & cmd_i.data[hcai_pkg::DIR_CLR_IF_BIT]);
  assign clear_interrupt_enables = clear_interface
    | (director_function_decode & cmd_i.data[hcai_pkg::DIR_CLR_INT_BIT]);

  // wishbone decode
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign wb_hit = (wb_adr_i == hcai_pkg::ADDR_CTRL) | (wb_adr_i == hcai_pkg::ADDR_STAT)
    | (wb_adr_i == hcai_pkg::ADDR_IEN) | (wb_adr_i == hcai_pkg::ADDR_CFG);
  assign fw_reply_strobe = wb_wr & (wb_adr_i == hcai_pkg::ADDR_CTRL)
    & wb_dat_i[hcai_pkg::CTRL_REPLY_BIT];
  assign fw_reject_strobe = wb_wr & (wb_adr_i == hcai_pkg::ADDR_CTRL)
    & wb_dat_i[hcai_pkg::CTRL_REJECT_BIT];
  assign seek_clr_strobe = wb_wr & (wb_adr_i == hcai_pkg::ADDR_CTRL)
    & wb_dat_i[hcai_pkg::CTRL_SEEK_CLR_BIT];

  // select history for edge detection
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sel_d_q <= 1'b0;
    else
      sel_d_q <= qualified_select;
  end

  // accepted flag: set wins over a clear; a firmware reject takes it back so one flag stands
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      accepted_q <= 1'b0;
    else if (~qualified_select)
      accepted_q <= 1'b0;
    else if (fw_reject_strobe)
      accepted_q <= 1'b0;
    else if (cmd_start & accept_ok)
      accepted_q <= 1'b1;
    else if (clear_interface)
      accepted_q <= 1'b0;
  end

  // reject flag: failed conditions or controlware strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reject_q <= 1'b0;
    else if (cmd_start & ~accept_ok)
      reject_q <= 1'b1;
    else if (fw_reject_strobe & qualified_select)
      reject_q <= 1'b1;
    else if (~qualified_select | clear_interface)
      reject_q <= 1'b0;
  end

  // reply flag: automatic for code 8, otherwise controlware
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reply_q <= 1'b0;
    else if (accepted_q & is_fc8 & prot_ok & qualified_select)
      reply_q <= 1'b1;
    else if (fw_reply_strobe & accepted_q & ~is_fc8 & qualified_select)
      reply_q <= 1'b1;
    else if (~qualified_select | clear_interface)
      reply_q <= 1'b0;
  end

  // command capture for controlware dispatch
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fc_q <= 4'h0;
      write_q <= 1'b0;
      data_q <= 16'h0000;
    end
    else if (cmd_start & accept_ok)
    begin
      fc_q <= fc;
      write_q <= cmd_i.wr;
      data_q <= cmd_i.data;
    end
  end

  // busy: set by any ordinary accepted command, released by controlware
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      busy_q <= 1'b0;
    else if (clear_interface)
      busy_q <= 1'b0;
    else if (cmd_start & accept_ok & ~is_fc8)
      busy_q <= 1'b1;
    else if (wb_wr & (wb_adr_i == hcai_pkg::ADDR_CTRL))
      busy_q <= wb_dat_i[hcai_pkg::CTRL_BUSY_BIT];
  end

  // configuration: protect jumper and equipment address
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prot_cfg_q <= 1'b0;
      dev_addr_q <= hcai_pkg::DEV_ADDR_RST;
    end
    else if (wb_wr & (wb_adr_i == hcai_pkg::ADDR_CFG))
    begin
      prot_cfg_q <= wb_dat_i[hcai_pkg::CFG_PROT_BIT];
      dev_addr_q <= wb_dat_i[3:0];
    end
  end

  // seek latch: set wins over clear so no pulse is lost
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      seek_done_latch_q <= 1'b0;
    else if (seek_alert_i)
      seek_done_latch_q <= 1'b1;
    else if (seek_clr_strobe | clear_interface)
      seek_done_latch_q <= 1'b0;
  end

  // interrupt enable latches
  hcai_ien #(
    .N_EN(8),
    .N_SRC(N_SRC)
  ) u_ien (
    .mclk(mclk),
    .rst(rst),
    .clr(clear_interrupt_enables),
    .wr_en(director_function_decode),
    .sel(cmd_i.data[hcai_pkg::DIR_SEL_LSB +: 3]),
    .set_val(cmd_i.data[hcai_pkg::DIR_SET_BIT]),
    .cond({int_cond_i, seek_done_latch_q}),
    .en_q(en_q),
    .any_o(int_any)
  );

  // wired-or interrupt driver, registered
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_request_n_o <= 1'b1;
      interrupt_request_n_oe <= 1'b0;
    end
    else
    begin
      interrupt_request_n_o <= ~int_any;
      interrupt_request_n_oe <= int_any;
    end
  end

  // status word returned on a code 8 read
  always_comb
  begin
    status_word = 16'h0000;
    status_word[hcai_pkg::STATUS_SEEK_BIT] = seek_done_latch_q;
  end

  // status data frozen once sampled; stable until read drops
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_o <= 16'h0000;
      rd_data_oe <= 1'b0;
    end
    else if (~(qualified_select & cmd_i.rd))
    begin
      rd_data_oe <= 1'b0;
      rd_data_o <= 16'h0000;
    end
    else if (accepted_q & is_fc8 & ~reply_q)
    begin
      rd_data_o <= status_word;
      rd_data_oe <= 1'b1;
    end
  end

  // flag and clear outputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      flags_o <= '0;
      clear_interface_o <= 1'b0;
    end
    else
    begin
      flags_o <= '{accepted: accepted_q, reply: reply_q, reject: reject_q};
      clear_interface_o <= clear_interface;
    end
  end

  // wishbone slave: one-cycle ack, err on unmapped address
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req & wb_hit;
      wb_err_o <= wb_req & ~wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req & ~wb_we_i)
      begin
        case (wb_adr_i)
          hcai_pkg::ADDR_CTRL: wb_dat_o[hcai_pkg::CTRL_BUSY_BIT] <= busy_q;
          hcai_pkg::ADDR_STAT:
          begin
            wb_dat_o[hcai_pkg::STAT_ACC_BIT] <= accepted_q;
            wb_dat_o[hcai_pkg::STAT_REP_BIT] <= reply_q;
            wb_dat_o[hcai_pkg::STAT_REJ_BIT] <= reject_q;
            wb_dat_o[hcai_pkg::STAT_WRITE_BIT] <= write_q;
            wb_dat_o[hcai_pkg::STAT_SEEK_BIT] <= seek_done_latch_q;
            wb_dat_o[hcai_pkg::STAT_FC_LSB +: 4] <= fc_q;
            wb_dat_o[hcai_pkg::STAT_DATA_LSB +: 16] <= data_q;
          end
          hcai_pkg::ADDR_IEN: wb_dat_o[7:0] <= en_q;
          hcai_pkg::ADDR_CFG:
          begin
            wb_dat_o[3:0] <= dev_addr_q;
            wb_dat_o[hcai_pkg::CFG_PROT_BIT] <= prot_cfg_q;
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

/* File: verif/hcai_cpu_model.sv */
// processor backplane and seek alert model
`timescale 1ns/100ps
module hcai_cpu_model (
  input wire logic mclk, // clock
  input wire hcai_pkg::hcai_flags_t flags_i, // device flags
  input wire logic [15:0] rd_data_i, // status data
  output hcai_pkg::hcai_cmd_t cmd_o, // command lines
  output logic seek_o // alert line
);
  initial
  begin
    cmd_o = '0;
    seek_o = 1'b0;
  end
  // raise a command and hold it until the device answers
  task automatic start(input logic w, input logic [3:0] fc, a, input logic p,
      input logic [15:0] d, output hcai_pkg::hcai_flags_t f);
    @(posedge mclk);
    cmd_o <= '{rd: !w, wr: w, adr_n: ~a, fc_n: ~fc, prot_n: p, data: d};
    for (int i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (flags_i.accepted || flags_i.reject)
        break;
    end
    f = flags_i;
  endtask
  // wait for reply, then release; lines show inverted junk once dropped
  task automatic finish(output hcai_pkg::hcai_flags_t f, output logic [15:0] q);
    for (int i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (flags_i.reply || flags_i.reject)
        break;
    end
    f = flags_i;
    q = rd_data_i;
    cmd_o <= {2'b00, ~cmd_o[24:0]};
    repeat (3) @(posedge mclk);
  endtask
  // 1 us at 100 MHz
  task automatic seek_pulse;
    @(posedge mclk);
    seek_o <= 1'b1;
    repeat (100) @(posedge mclk);
    seek_o <= 1'b0;
  endtask
endmodule

/* File: verif/hcai_monitor.sv */
// port checker for the command accept and interrupt block
`timescale 1ns/100ps
module hcai_monitor (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire hcai_pkg::hcai_cmd_t cmd_i, // command lines
  input wire logic master_reset_in, // master reset
  input wire logic [15:0] rd_data_o, // status data
  input wire logic rd_data_oe, // data enable
  input wire logic interrupt_request_n_o, // irq line
  input wire logic interrupt_request_n_oe, // irq enable
  input wire hcai_pkg::hcai_flags_t flags_o, // answer flags
  input wire logic clear_interface_o, // clear pulse
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o // acknowledge
);
  logic sel;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // limitation: assumes the device address keeps its reset value
  assign sel = (cmd_i.rd | cmd_i.wr) & (cmd_i.adr_n == 4'hF);
  one_flag_a: assert property (!(flags_o.accepted && flags_o.reject))
    else $error("accepted and reject together");
  cmd_taken_a: assert property ($rose(sel) |-> ##[1:3] (flags_o.accepted || flags_o.reject))
    else $error("command got no answer");
  auto_reply_a: assert property ($rose(flags_o.accepted) && cmd_i.wr && cmd_i.fc_n == 4'h7
    && !cmd_i.data[6] |=> flags_o.reply) else $error("director reply late");
  strobe_reply_a: assert property ($rose(flags_o.accepted) && cmd_i.fc_n != 4'h7
    |=> !flags_o.reply) else $error("reply without strobe");
  drop_clear_a: assert property ($fell(cmd_i.rd || cmd_i.wr) |-> ##[1:3] flags_o == 3'h0)
    else $error("flags not cleared");
  idle_quiet_a: assert property (!sel && !$past(sel) && !$past(sel, 2) && !$past(sel, 3)
    |-> flags_o == 3'h0) else $error("flags while unselected");
  irq_drive_a: assert property (interrupt_request_n_oe == !interrupt_request_n_o)
    else $error("irq enable mismatch");
  clear_mr_a: assert property (master_reset_in |-> ##[1:2] clear_interface_o)
    else $error("no clear on master reset");
  data_hold_a: assert property (rd_data_oe && $past(rd_data_oe) && cmd_i.rd
    |-> $stable(rd_data_o)) else $error("status data moved");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  cover property ($rose(flags_o.reply));
  cover property ($rose(flags_o.reject));
  cover property ($fell(interrupt_request_n_o));
endmodule
bind hcai_top hcai_monitor u_mon (
  .mclk(mclk), .rst(rst), .cmd_i(cmd_i), .master_reset_in(master_reset_in),
  .rd_data_o(rd_data_o), .rd_data_oe(rd_data_oe),
  .interrupt_request_n_o(interrupt_request_n_o),
  .interrupt_request_n_oe(interrupt_request_n_oe), .flags_o(flags_o),
  .clear_interface_o(clear_interface_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

/* File: verif/testbench.sv */
// self-checking bench for the command accept and interrupt block
`timescale 1ns/100ps
module testbench;
  localparam hcai_pkg::hcai_flags_t NON = 3'b000;
  localparam hcai_pkg::hcai_flags_t ACC = 3'b100;
  localparam hcai_pkg::hcai_flags_t ACR = 3'b110;
  localparam hcai_pkg::hcai_flags_t REJ = 3'b001;
  logic mclk, rst, mr, cyc, stb, we, seek, irq_n, ack, err, e;
  logic [7:0] adr;
  logic [3:0] bsel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] rd, rdo;
  logic [5:1] cond;
  int mismatches, samples_checked;
  hcai_pkg::hcai_cmd_t cmd;
  hcai_pkg::hcai_flags_t flags, f;
  hcai_top DUT (
    .mclk(mclk), .rst(rst), .cmd_i(cmd), .master_reset_in(mr), .seek_alert_i(seek),
    .int_cond_i(cond), .rd_data_o(rdo), .rd_data_oe(), .interrupt_request_n_o(irq_n),
    .interrupt_request_n_oe(), .flags_o(flags), .clear_interface_o(), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(bsel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err)
  );
  hcai_cpu_model cpu (.mclk(mclk), .flags_i(flags), .rd_data_i(rdo), .cmd_o(cmd),
    .seek_o(seek));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_f(input hcai_pkg::hcai_flags_t g, x);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: flags %b exp %b", $time, g, x);
    end
  endtask
  task automatic chk32(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: word %h exp %h", $time, g, x);
    end
  endtask
  // classic single wishbone cycle, held until ack or err
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, bsel} <= {2'b11, w, a, d, 4'hF};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    r = rdat;
    e = err;
    {cyc, stb} <= 2'b00;
    if (n >= 50)
      mismatches++;
  endtask
  // whole command; cw nonzero is written to control before release
  task automatic op(input logic w, input logic [3:0] fc, a, input logic p,
      input logic [15:0] d, input hcai_pkg::hcai_flags_t e1, e2, input logic [31:0] cw);
    cpu.start(w, fc, a, p, d, f);
    chk_f(f, e1);
    if (cw != 32'h0)
      wb(1'b1, hcai_pkg::ADDR_CTRL, cw, q);
    cpu.finish(f, rd);
    chk_f(f, e2);
  endtask
  // director write, then line level and enable register
  task automatic ien(input logic [15:0] d, input logic ei, input logic [31:0] ee);
    cpu.start(1'b1, 4'h8, 4'h0, 1'b1, d, f);
    cpu.finish(f, rd);
    repeat (3) @(posedge mclk);
    chk32({31'h0, irq_n}, {31'h0, ei});
    wb(1'b0, hcai_pkg::ADDR_IEN, 32'h0, q);
    chk32(q, ee);
  endtask
  initial
  begin
    {rst, mr, cyc, stb, we, adr, wdat, bsel, cond} = {1'b1, 53'h0};
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b0, hcai_pkg::ADDR_CFG, 32'h0, q);
    chk32(q, 32'h0);
    wb(1'b0, 8'h10, 32'h0, q);
    chk32({31'h0, e}, 32'h1);
    $display("test registers done");
    op(1'b0, 4'h8, 4'h0, 1'b1, 16'h0, ACC, ACR, 32'h0);
    chk32({31'h0, rd[0]}, 32'h0);
    cpu.start(1'b1, 4'h3, 4'h0, 1'b1, 16'hA5C3, f);
    chk_f(f, ACC);
    wb(1'b0, hcai_pkg::ADDR_STAT, 32'h0, q);
    chk32(q & 32'hFFFF0F1F, 32'hA5C30309);
    wb(1'b1, hcai_pkg::ADDR_CTRL, 32'h5, q);
    cpu.finish(f, rd);
    chk_f(f, ACR);
    op(1'b1, 4'h5, 4'h0, 1'b1, 16'h0, REJ, REJ, 32'h0);
    op(1'b0, 4'h8, 4'h0, 1'b1, 16'h0, ACC, ACR, 32'h0);
    wb(1'b1, hcai_pkg::ADDR_CTRL, 32'h0, q);
    op(1'b1, 4'h3, 4'h0, 1'b1, 16'h0, ACC, REJ, 32'h2);
    op(1'b1, 4'h3, 4'h5, 1'b1, 16'h0, NON, NON, 32'h0);
    $display("test accept done");
    wb(1'b1, hcai_pkg::ADDR_CFG, 32'h10, q);
    op(1'b1, 4'h2, 4'h0, 1'b1, 16'h0, REJ, REJ, 32'h0);
    op(1'b1, 4'h2, 4'h0, 1'b0, 16'h0, ACC, ACR, 32'h1);
    cpu.start(1'b0, 4'h8, 4'h0, 1'b1, 16'h0, f);
    chk_f(f, ACC);
    cpu.finish(f, rd);
    wb(1'b1, hcai_pkg::ADDR_CFG, 32'h0, q);
    $display("test protect done");
    cpu.seek_pulse();
    op(1'b0, 4'h8, 4'h0, 1'b1, 16'h0, ACC, ACR, 32'h0);
    chk32({31'h0, rd[0]}, 32'h1);
    wb(1'b0, hcai_pkg::ADDR_STAT, 32'h0, q);
    chk32({31'h0, q[4]}, 32'h1);
    cond <= 5'b00100;
    ien(16'h0000, 1'b1, 32'h0);
    ien(16'h0020, 1'b0, 32'h1);
    ien(16'h0080, 1'b1, 32'h0);
    ien(16'h002C, 1'b0, 32'h8);
    ien(16'h0040, 1'b1, 32'h0);
    ien(16'h002C, 1'b0, 32'h8);
    mr <= 1'b1;
    @(posedge mclk);
    mr <= 1'b0;
    repeat (3) @(posedge mclk);
    chk32({31'h0, irq_n}, 32'h1);
    wb(1'b0, hcai_pkg::ADDR_IEN, 32'h0, q);
    chk32(q, 32'h0);
    $display("test interrupts done");
    summarize();
  end
  // hang guard, well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    summarize();
  end
endmodule
